//--- phy_timing_pkg.sv
// Timing constants and carriers for the PHY parallel-side model
package phy_timing_pkg;

    // ========
    // Clock periods, in ns
    localparam real SYS_CLK_NS  = 40.0;
    localparam real LINK_CLK_NS = 64.0;

    // ========
    // Latency limits, longest times, in ns
    localparam real TX_LAT_MAX_NS   = 33.2;
    localparam real RX_LAT_MAX_NS   = 93.2;
    localparam real LPBK_LAT_MAX_NS = 29.2;
    localparam real P0_RET_MAX_NS   = 32.0;
    localparam real RST_RDY_MAX_NS  = 11.0;
    localparam real LOCK_MAX_NS     = 4000.0;

    // Longest time rounds down, never below one cycle
    function automatic int cyc_dn(real t_ns, real per_ns);
        int c;
        c = $rtoi(t_ns / per_ns);
        return (c < 1) ? 1 : c;
    endfunction : cyc_dn

    localparam int TX_LAT_CYC   = cyc_dn(TX_LAT_MAX_NS, LINK_CLK_NS);
    localparam int RX_LAT_CYC   = cyc_dn(RX_LAT_MAX_NS, SYS_CLK_NS);
    localparam int LPBK_LAT_CYC = cyc_dn(LPBK_LAT_MAX_NS, LINK_CLK_NS);
    localparam int P0_RET_CYC   = cyc_dn(P0_RET_MAX_NS, SYS_CLK_NS);
    localparam int RST_RDY_CYC  = cyc_dn(RST_RDY_MAX_NS, SYS_CLK_NS);
    localparam int LOCK_CYC_DEF = cyc_dn(LOCK_MAX_NS, LINK_CLK_NS);

    // ========
    // Widths and codes
    localparam int         TMR_W          = 4;
    localparam int         CNT_W          = 16;
    localparam int         FIFO_DEPTH_DEF = 4;
    localparam logic [7:0] NFTS_COMMON    = 8'h17;
    localparam logic [7:0] NFTS_SEPARATE  = 8'hff;

    typedef enum logic [1:0] {
        PD_P0  = 2'h0,
        PD_P0S = 2'h1,
        PD_P1  = 2'h2,
        PD_P2  = 2'h3
    } pwr_t;

    typedef enum logic [3:0] {
        ST_RESET  = 4'h1,
        ST_ACTIVE = 4'h2,
        ST_LOW    = 4'h4,
        ST_WAKE   = 4'h8
    } pstate_t;

    // Rise byte is the low byte of the pair
    typedef struct packed {
        logic [7:0] fall_byte;
        logic [7:0] rise_byte;
    } lane_word_t;

    typedef struct packed {
        logic       valid;
        lane_word_t data;
    } beat_t;

    localparam int WORD_W = $bits(lane_word_t);

endpackage : phy_timing_pkg

//--- pipe_phy_timing_behaviour.sv
// PHY timing model: parallel side, power states, link side, lock
`timescale 1ns/10ps
// Behaviour
// - Transmit word goes out serially within 33.2 ns of its transfer.
// - Received word reaches the parallel side within 93.2 ns of arrival.
// - Loopback retransmits received data within 29.2 ns of enable.
// - With a common clock, advertise 23 fast-training sets.
// - Without a common clock, advertise 255 fast-training sets.
// - Receiver locks within 4.0 us of training sets arriving.
// - Return from P0s to P0 raises ready indication within 32.0 ns.
// - Return from P1 to P0 raises ready indication within 32.0 ns.
// - Ready indication drops within 11.0 ns after reset release.
// - Parallel input carries two bytes per transmit clock, both edges.
// - Parallel output carries two bytes per receive clock, both edges.

// ========
// Word FIFO
module word_fifo #(
    parameter int W = 16,
    parameter int D = 4
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
    } fifo_st_t;

    fifo_st_t q_r;
    fifo_st_t q_nxt;
    logic     push;
    logic     pop;

    if (D < 2 || (1 << AW) != D) begin : g_bad_depth
        $error("word_fifo depth must be a power of two, at least 2");
    end

    assign in_ready  = (q_r.cnt != (AW+1)'(D));
    assign out_valid = (q_r.cnt != '0);
    assign out_data  = q_r.mem[q_r.rp];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        q_nxt = q_r;
        if (push) begin
            q_nxt.mem[q_r.wp] = in_data;
            q_nxt.wp          = q_r.wp + 1'b1;
        end
        if (pop) begin
            q_nxt.rp = q_r.rp + 1'b1;
        end
        q_nxt.cnt = q_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        if (rst) begin
            q_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        q_r <= q_nxt;
    end
endmodule : word_fifo

// ========
// Top
module pipe_phy_timing_behaviour #(
    parameter int LOCK_CYC   = phy_timing_pkg::LOCK_CYC_DEF,
    parameter int FIFO_DEPTH = phy_timing_pkg::FIFO_DEPTH_DEF
) (
    input  wire logic                   SYS_CLK,
    input  wire logic                   RST,
    input  wire phy_timing_pkg::beat_t  TX_BEAT,
    output logic                        TX_READY,
    output phy_timing_pkg::beat_t       RX_BEAT,
    input  wire phy_timing_pkg::pwr_t   POWER_DOWN,
    input  wire logic                   LOOPBACK,
    input  wire logic                   COMMON_CLK,
    output logic                        PHY_READY_INDICATION,
    output logic [7:0]                  NFTS_REQ,
    output logic                        RX_LOCKED,
    input  wire logic                   LINK_CLK,
    input  wire logic                   LINK_RST,
    input  wire phy_timing_pkg::beat_t  SER_RX,
    input  wire logic                   SER_TRAIN,
    output phy_timing_pkg::beat_t       SER_TX
);
    import phy_timing_pkg::*;

    localparam logic [TMR_W-1:0] RST_INIT  = TMR_W'(RST_RDY_CYC - 1);
    localparam logic [TMR_W-1:0] WAKE_INIT = TMR_W'(P0_RET_CYC - 1);
    localparam logic [CNT_W-1:0] LOCK_LAST = CNT_W'(LOCK_CYC - 1);
    localparam int TX_D   = TX_LAT_CYC;
    localparam int RX_D   = RX_LAT_CYC;
    localparam int LP_D   = LPBK_LAT_CYC;
    localparam int WAKE_D = P0_RET_CYC;
    localparam int RDY_D  = RST_RDY_CYC;

    if (LOCK_CYC < 1 || LOCK_CYC >= (1 << CNT_W)) begin : g_bad_lock
        $error("LOCK_CYC out of counter range");
    end

    // Parallel-side state
    typedef struct packed {
        pstate_t          st;
        logic [TMR_W-1:0] tmr;
        logic             ready_ind;
        logic [1:0]       strap_s;
        logic [7:0]       nfts;
        logic [1:0]       lock_s;
        logic             tx_req;
        lane_word_t       tx_hold;
        logic [1:0]       ack_s;
        logic [1:0]       rxq_s;
        logic             rx_seen;
        beat_t            rx_out;
    } sys_st_t;

    // Link-side state
    typedef struct packed {
        logic [1:0]       lp_s;
        logic [1:0]       txq_s;
        logic             tx_seen;
        beat_t            ser_tx;
        logic             rx_req;
        lane_word_t       rx_hold;
        logic [1:0]       rxa_s;
        logic [CNT_W-1:0] train_cnt;
        logic             locked;
    } lnk_st_t;

    sys_st_t    s_r;
    sys_st_t    s_nxt;
    lnk_st_t    l_r;
    lnk_st_t    l_nxt;
    logic       f_valid;
    logic       f_pop;
    lane_word_t f_data;

    // ========
    // Transmit buffer
    word_fifo #(
        .W (WORD_W),
        .D (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (SYS_CLK),
        .rst       (RST),
        .in_valid  (TX_BEAT.valid),
        .in_ready  (TX_READY),
        .in_data   (TX_BEAT.data),
        .out_valid (f_valid),
        .out_ready (f_pop),
        .out_data  (f_data)
    );

    // Drain only in P0 and with no word in flight to the link side
    assign f_pop = f_valid && (s_r.st == ST_ACTIVE) && (s_r.tx_req == s_r.ack_s[1]);

    // ========
    // Parallel side
    always_comb begin
        s_nxt              = s_r;
        s_nxt.ready_ind    = 1'b0;
        s_nxt.rx_out.valid = 1'b0;
        s_nxt.strap_s      = {s_r.strap_s[0], COMMON_CLK};
        s_nxt.nfts         = s_r.strap_s[1] ? NFTS_COMMON : NFTS_SEPARATE;
        s_nxt.lock_s       = {s_r.lock_s[0], l_r.locked};
        s_nxt.ack_s        = {s_r.ack_s[0], l_r.tx_seen};
        s_nxt.rxq_s        = {s_r.rxq_s[0], l_r.rx_req};
        if (s_r.rxq_s[1] != s_r.rx_seen) begin
            s_nxt.rx_seen      = s_r.rxq_s[1];
            s_nxt.rx_out.valid = 1'b1;
            s_nxt.rx_out.data  = l_r.rx_hold;
        end
        if (f_pop) begin
            s_nxt.tx_req  = ~s_r.tx_req;
            s_nxt.tx_hold = f_data;
        end
        case (s_r.st)
            ST_RESET: begin
                if (s_r.tmr == '0) begin
                    s_nxt.st = ST_ACTIVE;
                end else begin
                    s_nxt.tmr       = s_r.tmr - 1'b1;
                    s_nxt.ready_ind = 1'b1;
                end
            end
            ST_ACTIVE: begin
                if (POWER_DOWN != PD_P0) begin
                    s_nxt.st = ST_LOW;
                end
            end
            ST_LOW: begin
                if (POWER_DOWN == PD_P0) begin
                    if (WAKE_INIT == '0) begin
                        s_nxt.st        = ST_ACTIVE;
                        s_nxt.ready_ind = 1'b1;
                    end else begin
                        s_nxt.tmr = WAKE_INIT;
                        s_nxt.st  = ST_WAKE;
                    end
                end
            end
            ST_WAKE: begin
                if (s_r.tmr == '0) begin
                    s_nxt.st        = ST_ACTIVE;
                    s_nxt.ready_ind = 1'b1;
                end else begin
                    s_nxt.tmr = s_r.tmr - 1'b1;
                end
            end
            default: begin
                s_nxt.st = ST_RESET;
            end
        endcase
        if (RST) begin
            s_nxt           = '0;
            s_nxt.st        = ST_RESET;
            s_nxt.tmr       = RST_INIT;
            s_nxt.ready_ind = 1'b1;
        end
    end

    always_ff @(posedge SYS_CLK) begin
        s_r <= s_nxt;
    end

    // ========
    // Link side
    // Words cross by toggle handshake; the hold registers stay put until acknowledged
    always_comb begin
        l_nxt              = l_r;
        l_nxt.ser_tx.valid = 1'b0;
        l_nxt.lp_s         = {l_r.lp_s[0], LOOPBACK};
        l_nxt.txq_s        = {l_r.txq_s[0], s_r.tx_req};
        l_nxt.rxa_s        = {l_r.rxa_s[0], s_r.rx_seen};
        if (l_r.lp_s[1]) begin
            l_nxt.ser_tx = SER_RX;
        end else if (l_r.txq_s[1] != l_r.tx_seen) begin
            l_nxt.tx_seen      = l_r.txq_s[1];
            l_nxt.ser_tx.valid = 1'b1;
            l_nxt.ser_tx.data  = s_r.tx_hold;
        end
        if (!SER_TRAIN) begin
            l_nxt.train_cnt = '0;
        end else if (!l_r.locked) begin
            if (l_r.train_cnt == LOCK_LAST) begin
                l_nxt.locked = 1'b1;
            end else begin
                l_nxt.train_cnt = l_r.train_cnt + 1'b1;
            end
        end
        // A word arriving while the previous is unacknowledged is dropped
        if (SER_RX.valid && l_r.locked && (l_r.rx_req == l_r.rxa_s[1])) begin
            l_nxt.rx_req  = ~l_r.rx_req;
            l_nxt.rx_hold = SER_RX.data;
        end
        if (LINK_RST) begin
            l_nxt = '0;
        end
    end

    always_ff @(posedge LINK_CLK) begin
        l_r <= l_nxt;
    end

    assign PHY_READY_INDICATION = s_r.ready_ind;
    assign NFTS_REQ             = s_r.nfts;
    assign RX_LOCKED            = s_r.lock_s[1];
    assign RX_BEAT              = s_r.rx_out;
    assign SER_TX               = l_r.ser_tx;

    // ========
    // Checks
    logic [CNT_W-1:0] h_train;

    always_ff @(posedge LINK_CLK) begin
        if (LINK_RST || !SER_TRAIN) begin
            h_train <= '0;
        end else if (h_train != '1) begin
            h_train <= h_train + 1'b1;
        end
    end

    a_nfts_common:
    assert property (@(posedge SYS_CLK) disable iff (RST)
        s_r.strap_s[1] |=> NFTS_REQ == NFTS_COMMON)
    else $error("Common clock count wrong");
    a_nfts_separate:
    assert property (@(posedge SYS_CLK) disable iff (RST)
        !s_r.strap_s[1] |=> NFTS_REQ == NFTS_SEPARATE)
    else $error("Separate clock count wrong");

    a_wake_from_p0s:
    assert property (@(posedge SYS_CLK) disable iff (RST)
        (s_r.st == ST_LOW && POWER_DOWN == PD_P0 && $past(POWER_DOWN) == PD_P0S)
        |-> ##WAKE_D PHY_READY_INDICATION)
    else $error("Late ready after P0s exit");
    a_wake_from_p1:
    assert property (@(posedge SYS_CLK) disable iff (RST)
        (s_r.st == ST_LOW && POWER_DOWN == PD_P0 && $past(POWER_DOWN) == PD_P1)
        |-> ##WAKE_D PHY_READY_INDICATION)
    else $error("Late ready after P1 exit");

    a_reset_ready:
    assert property (@(posedge SYS_CLK) disable iff (RST)
        $fell(RST) |-> ##RDY_D !PHY_READY_INDICATION)
    else $error("Ready not dropped after reset");
    a_rx_present:
    assert property (@(posedge SYS_CLK) disable iff (RST)
        (s_r.rxq_s[1] != s_r.rx_seen) |-> ##[1:RX_D] RX_BEAT.valid)
    else $error("Received word late");

    a_tx_launch:
    assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
        (!l_r.lp_s[1] && l_r.txq_s[1] != l_r.tx_seen)
        |-> ##TX_D (SER_TX.valid && SER_TX.data == $past(s_r.tx_hold, TX_D)))
    else $error("Transmit word late or wrong");
    a_loop_echo:
    assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
        l_r.lp_s[1] |-> ##LP_D SER_TX == $past(SER_RX, LP_D))
    else $error("Loopback data not echoed");

    a_lock_time:
    assert property (@(posedge LINK_CLK) disable iff (LINK_RST)
        (h_train >= CNT_W'(LOCK_CYC)) |-> l_r.locked)
    else $error("Lock not reached in time");
endmodule : pipe_phy_timing_behaviour

//--- link_partner.sv
// Link-side far end: sends training and words, collects transmitted words
`timescale 1ns/10ps
module link_partner (
    input  wire logic                  LINK_CLK,
    output phy_timing_pkg::beat_t      SER_RX,
    output logic                       SER_TRAIN,
    input  wire phy_timing_pkg::beat_t SER_TX
);
    import phy_timing_pkg::*;
    lane_word_t txq[$];

    initial begin
        SER_RX    = '{valid: 1'b0, data: 16'h5a5a};
        SER_TRAIN = 1'b0;
    end

    // ========
    // Training held on, lock never drops on its own
    task train();
        @(posedge LINK_CLK);
        #1 SER_TRAIN = 1'b1;
    endtask : train

    // Idle data flips so a stale word never looks valid
    task send(input lane_word_t w);
        @(posedge LINK_CLK);
        #1 SER_RX = '{valid: 1'b1, data: w};
        @(posedge LINK_CLK);
        #1 SER_RX = '{valid: 1'b0, data: ~w};
    endtask : send

    always @(posedge LINK_CLK) begin
        if (SER_TX.valid === 1'b1) begin
            txq.push_back(SER_TX.data);
        end
    end
endmodule : link_partner

//--- tb.sv
// Self-checking bench for the PHY timing model
`timescale 1ns/10ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (b)); end end
module tb;
    import phy_timing_pkg::*;
    logic       SYS_CLK, RST, LINK_CLK, LINK_RST, LOOPBACK, COMMON_CLK;
    logic       TX_READY, PHY_READY_INDICATION, RX_LOCKED, SER_TRAIN;
    logic [7:0] NFTS_REQ;
    beat_t      TX_BEAT, RX_BEAT, SER_RX, SER_TX;
    pwr_t       POWER_DOWN;
    int         err_count, n_compared, cyc;

    // Small lock count keeps the run short
    pipe_phy_timing_behaviour #(.LOCK_CYC(4), .FIFO_DEPTH(4)) dut_u (
        .SYS_CLK(SYS_CLK), .RST(RST), .TX_BEAT(TX_BEAT), .TX_READY(TX_READY),
        .RX_BEAT(RX_BEAT), .POWER_DOWN(POWER_DOWN), .LOOPBACK(LOOPBACK),
        .COMMON_CLK(COMMON_CLK), .PHY_READY_INDICATION(PHY_READY_INDICATION),
        .NFTS_REQ(NFTS_REQ), .RX_LOCKED(RX_LOCKED), .LINK_CLK(LINK_CLK),
        .LINK_RST(LINK_RST), .SER_RX(SER_RX), .SER_TRAIN(SER_TRAIN), .SER_TX(SER_TX));
    link_partner link_u (.LINK_CLK(LINK_CLK), .SER_RX(SER_RX), .SER_TRAIN(SER_TRAIN), .SER_TX(SER_TX));

    // ========
    // Clocks, unrelated phases
    initial begin
        SYS_CLK = 1'b0;
        forever #20 SYS_CLK = ~SYS_CLK;
    end
    initial begin
        LINK_CLK = 1'b0;
        #7;
        forever #32 LINK_CLK = ~LINK_CLK;
    end

    task step(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : step

    task complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    always @(posedge SYS_CLK) begin
        cyc++;
        if (cyc > 6000) begin
            err_count++;
            complete_run();
        end
    end

    // ========
    // Handshake helpers
    task tx_push(input lane_word_t w);
        int k;
        TX_BEAT = '{valid: 1'b1, data: w};
        k = 0;
        while (TX_READY !== 1'b1 && k < 50) begin
            step(1);
            k++;
        end
        `CHK(TX_READY, 1'b1)
        step(1);
    endtask : tx_push

    task tx_expect(input lane_word_t w);
        int         k;
        lane_word_t g;
        k = 0;
        g = ~w;
        while (link_u.txq.size() == 0 && k < 40) begin
            step(1);
            k++;
        end
        if (link_u.txq.size() > 0) begin
            g = link_u.txq.pop_front();
        end
        `CHK(g, w)
    endtask : tx_expect

    task rx_expect(input lane_word_t w);
        int k;
        k = 0;
        while (RX_BEAT.valid !== 1'b1 && k < 8) begin
            step(1);
            k++;
        end
        `CHK(RX_BEAT.valid, 1'b1)
        `CHK(RX_BEAT.data, w)
        step(1);
        `CHK(RX_BEAT.valid, 1'b0)
    endtask : rx_expect

    task wake_check(input pwr_t low);
        POWER_DOWN = low;
        step(3);
        `CHK(PHY_READY_INDICATION, 1'b0)
        POWER_DOWN = PD_P0;
        step(1);
        `CHK(PHY_READY_INDICATION, 1'b1)
        step(1);
        `CHK(PHY_READY_INDICATION, 1'b0)
    endtask : wake_check

    // ========
    // Scenarios
    task t_reset();
        `CHK(PHY_READY_INDICATION, 1'b1)
        RST = 1'b0;
        step(1);
        `CHK(PHY_READY_INDICATION, 1'b0)
        step(3);
        `CHK(NFTS_REQ, 8'h17)
        COMMON_CLK = 1'b0;
        step(4);
        `CHK(NFTS_REQ, 8'hff)
        $display("reset and fast-training count done");
    endtask : t_reset

    task t_lock();
        int k;
        `CHK(RX_LOCKED, 1'b0)
        link_u.train();
        k = 0;
        while (RX_LOCKED !== 1'b1 && k < 20) begin
            step(1);
            k++;
        end
        `CHK(RX_LOCKED, 1'b1)
        $display("lock done");
    endtask : t_lock

    task t_rx();
        link_u.send(16'hc3a1);
        rx_expect(16'hc3a1);
        step(6);
        link_u.send(16'h00ff);
        rx_expect(16'h00ff);
        $display("receive done");
    endtask : t_rx

    // Outside P0 nothing drains, so the FIFO fills and refuses
    task t_fill();
        POWER_DOWN = PD_P1;
        step(2);
        for (int i = 0; i < 4; i++) begin
            tx_push(16'h1100 + 16'(i));
        end
        `CHK(TX_READY, 1'b0)
        TX_BEAT = '{valid: 1'b0, data: 16'h0000};
        POWER_DOWN = PD_P0;
        step(1);
        `CHK(PHY_READY_INDICATION, 1'b1)
        for (int i = 0; i < 4; i++) begin
            tx_expect(16'h1100 + 16'(i));
        end
        `CHK(TX_READY, 1'b1)
        $display("transmit fill and drain done");
    endtask : t_fill

    task t_power();
        wake_check(PD_P0S);
        wake_check(PD_P1);
        tx_push(16'h7e81);
        TX_BEAT = '{valid: 1'b0, data: 16'h0000};
        tx_expect(16'h7e81);
        $display("power return done");
    endtask : t_power

    task t_loop();
        LOOPBACK = 1'b1;
        step(4);
        link_u.send(16'hbeef);
        tx_expect(16'hbeef);
        LOOPBACK = 1'b0;
        step(8);
        $display("loopback done");
    endtask : t_loop

    initial begin
        RST        = 1'b1;
        LINK_RST   = 1'b1;
        LOOPBACK   = 1'b0;
        COMMON_CLK = 1'b1;
        POWER_DOWN = PD_P0;
        TX_BEAT    = '{valid: 1'b0, data: 16'h0000};
        err_count  = 0;
        n_compared = 0;
        cyc        = 0;
        step(3);
        LINK_RST = 1'b0;
        t_reset();
        t_lock();
        t_rx();
        t_fill();
        t_power();
        t_loop();
        complete_run();
    end
endmodule : tb
